// *** scale_pkg.sv ***
// Constants shared by the scaling curve block, the source model and the bench
// Assumes a 10 MHz system clock and 32-bit register data
package scale_pkg;
  // Channel and source counts, value, guard and address widths
  localparam int NCH = 4;
  localparam int NSRC = 42;
  localparam int VAL_W = 32;
  localparam int GUARD = 8;
  localparam int ADDR_W = 10;

  // Source selection codes
  localparam int SRC_MA_OPT0 = 0;
  localparam int SRC_VOLT0 = 4;
  localparam int SRC_RTD0 = 24;
  localparam int SRC_MA_CARD0 = 40;
  localparam int SRC_LAST = 41;

  // Timing, in ns and ms, with derived step counts
  localparam int CLK_NS = 100;
  localparam int STEP_NS = 5_000_000;
  localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_MS = 5;
  localparam int FILT_TC_MS = 1000;
  localparam int UPD_MS = 150;
  localparam logic [15:0] FILT_TC_DEF = 16'(FILT_TC_MS / STEP_MS);
  localparam logic [15:0] UPD_DEF = 16'(UPD_MS / STEP_MS);

  // Global register byte offsets (page 0)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IRQ_ST = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFS_OOR = 12'h00c;
  localparam int CTRL_EN = 0;

  // Channel pages: channel c sits in 256-byte page CH_PAGE + c
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [7:0] CH_CFG = 8'h00;
  localparam logic [7:0] CH_TC = 8'h04;
  localparam logic [7:0] CH_UPD = 8'h08;
  localparam logic [7:0] CH_MIN = 8'h0c;
  localparam logic [7:0] CH_MAX = 8'h10;
  localparam logic [7:0] CH_IN = 8'h14;
  localparam logic [7:0] CH_OUT = 8'h18;
  localparam logic [7:0] CH_USED = 8'h1c;
  localparam logic [7:0] CH_PT = 8'h40;
  localparam int PT_SHIFT = 3;

  // Channel configuration fields
  localparam int CFG_EN = 0;
  localparam int CFG_FILT = 1;
  localparam int CFG_OOR = 2;
  localparam int CFG_RND_LSB = 4;
  localparam int CFG_SRC_LSB = 8;
  localparam int CFG_SRC_W = 6;
  localparam logic [31:0] CFG_MASK = 32'h0000_3f37;

  // Interrupt status layout
  localparam int IRQ_OOR_LSB = 0;
  localparam int IRQ_DONE_LSB = 4;

  // Input of second base point after reset, in whole units
  localparam int PT1_X = 1;

  // Rounding of the scaled value
  typedef enum logic [1:0] {
    RND_FLOAT = 2'h0,
    RND_FLOOR = 2'h1,
    RND_CEIL = 2'h2,
    RND_NEAR = 2'h3
  } round_t;
endpackage

// *** curve_divider.sv ***
// Sequential signed divider, one quotient bit per clock
// Assumes start only while idle; quotient truncates toward zero
`timescale 1ns/1ps
module curve_divider #(
  parameter int DW = 66
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request
  input wire logic start_i,
  input wire logic signed [DW-1:0] num_i,
  input wire logic signed [DW-1:0] den_i,
  // Result
  output logic signed [DW-1:0] quo_o,
  output logic done_o
);
  localparam int CNTW = $clog2(DW + 1);

  if (DW < 4) begin : g_bad
    $error("curve_divider: DW too small");
  end

  logic [DW-1:0] rem;
  logic [DW-1:0] quo;
  logic [DW-1:0] dmag;
  logic [CNTW-1:0] cnt;
  logic neg;
  logic busy;
  logic [DW:0] trial;
  logic [DW-1:0] next_quo;

  // Trial subtraction of the shifted remainder
  always_comb begin
    trial = {rem, quo[DW-1]} - {1'b0, dmag};
    next_quo = {quo[DW-2:0], ~trial[DW]};
  end

  // Restoring division sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rem <= '0;
      quo <= '0;
      dmag <= '0;
      cnt <= '0;
      neg <= 1'b0;
      busy <= 1'b0;
      quo_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        quo <= num_i[DW-1] ? DW'(-num_i) : num_i;
        dmag <= den_i[DW-1] ? DW'(-den_i) : den_i;
        neg <= num_i[DW-1] ^ den_i[DW-1];
        rem <= '0;
        cnt <= CNTW'(DW);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= trial[DW] ? {rem[DW-2:0], quo[DW-1]} : trial[DW-1:0];
        quo <= next_quo;
        cnt <= cnt - CNTW'(1);
        if (cnt == CNTW'(1)) begin
          busy <= 1'b0;
          done_o <= 1'b1;
          quo_o <= neg ? DW'(-next_quo) : next_quo;
        end
      end
    end
  end
endmodule // curve_divider

// *** scale_curves.sv ***
// Four analog input scaling channels behind an Avalon-MM slave
// Assumes sources and their presence flags are synchronous to CLOCK_I
// Summary of operation
// (RULE_01) Master enable off: no channel stores results.
// (RULE_02) Channel enable off: no sampling and no curve evaluation there.
// (RULE_03) Source code picks mA, voltage, RTD or card mA sample.
// (RULE_04) Filter on: running average replaces raw input; off: raw passes.
// (RULE_05) Filter time constant in 5 ms steps, default 1 s.
// (RULE_06) Filter is first order: acc += (raw - acc) / steps.
// (RULE_07) Out-of-range flag while input below minimum or above maximum.
// (RULE_08) Out-of-range flags leave the block as binary outputs.
// (RULE_09) Lost source keeps the last valid sample.
// (RULE_10) Recalculation every update cycle, 5 ms steps, default 150 ms.
// (RULE_11) Output kept, floored, ceiled or rounded to nearest integer.
// (RULE_12) Two base points; inputs default to 0 and 1.
// (RULE_13) Points three onward have used flags, up to 20 points.
// (RULE_14) Curve input readable per channel.
// (RULE_15) Scaled curve output readable per channel.
// (RULE_16) Interpolate between neighbouring used points; clamp at ends.
`timescale 1ns/1ps
module scale_curves #(
  parameter int FRAC_BITS = 16,
  parameter int NPTS = 20,
  parameter int TICK_CYCLES = scale_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // Avalon-MM slave, word address
  input wire logic [scale_pkg::ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [3:0] BYTEENABLE_I,
  input wire logic [31:0] WRITEDATA_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // Measurement samples, one word per source code
  input wire logic [scale_pkg::NSRC*scale_pkg::VAL_W-1:0] SRC_DATA_I,
  input wire logic [scale_pkg::NSRC-1:0] SRC_OK_I,
  // Flags and interrupt
  output logic [scale_pkg::NCH-1:0] CURVE_OUT_OF_RANGE_FLAG_O,
  output logic IRQ_O
);
  localparam int VW = scale_pkg::VAL_W;
  localparam int G = scale_pkg::GUARD;
  localparam int AW = VW + G;
  localparam int DW = 2 * VW + 2;
  localparam int NCH = scale_pkg::NCH;
  localparam int CW = $clog2(NCH);
  localparam int PW = $clog2(NPTS);
  localparam int TC1 = TICK_CYCLES - 1;
  localparam logic [VW-1:0] FMASK = (VW'(1) << FRAC_BITS) - VW'(1);
  localparam logic signed [VW-1:0] ONE = VW'(scale_pkg::PT1_X) << FRAC_BITS;
  localparam logic signed [VW-1:0] HALF = ONE >>> 1;

  if (NPTS < 2 || NPTS > 24 || FRAC_BITS < 1 || FRAC_BITS > 24 ||
      TICK_CYCLES < 2) begin : g_bad
    $error("scale_curves: unsupported parameter value");
  end

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_CHAN = 10'h002,
    S_FSTART = 10'h004,
    S_FWAIT = 10'h008,
    S_EVAL = 10'h010,
    S_SCAN = 10'h020,
    S_ISTART = 10'h040,
    S_IWAIT = 10'h080,
    S_STORE = 10'h100,
    S_NEXT = 10'h200
  } state_t;

  // Settings
  logic master_en;
  logic [7:0] irq_mask;
  logic [31:0] cfg [NCH];
  logic [15:0] tc [NCH];
  logic [15:0] upd [NCH];
  logic signed [VW-1:0] lim_lo [NCH];
  logic signed [VW-1:0] lim_hi [NCH];
  logic [NPTS-1:0] used [NCH];
  logic signed [VW-1:0] px [NCH][NPTS];
  logic signed [VW-1:0] py [NCH][NPTS];
  // Channel state
  logic signed [VW-1:0] raw [NCH];
  logic signed [AW-1:0] acc [NCH];
  logic signed [VW-1:0] cin [NCH];
  logic signed [VW-1:0] cout [NCH];
  logic [15:0] upd_cnt [NCH];
  logic [NCH-1:0] curve_out_of_range_flag;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] filt_en;
  logic [NCH-1:0] oor_en;
  logic [NCH-1:0] act;
  // Sequencer
  state_t state;
  logic [CW-1:0] chn;
  logic [PW-1:0] pidx;
  logic flo;
  logic fhi;
  logic signed [VW-1:0] xlo;
  logic signed [VW-1:0] ylo;
  logic signed [VW-1:0] xhi;
  logic signed [VW-1:0] yhi;
  logic signed [VW-1:0] res;
  logic signed [VW-1:0] cur;
  logic signed [AW:0] fdiff;
  logic signed [VW:0] dx;
  logic signed [VW:0] dy;
  logic [5:0] sel;
  logic sel_ok;
  logic signed [VW-1:0] sel_val;
  logic oor_hit;
  logic div_start;
  logic div_done;
  logic signed [DW-1:0] div_num;
  logic signed [DW-1:0] div_den;
  logic signed [DW-1:0] div_quo;
  logic [31:0] tick_cnt;
  logic tick;
  // Bus and interrupts
  logic wr_go;
  logic hit;
  logic ch_hit;
  logic pt_hit;
  logic dxy;
  logic [11:0] ba;
  logic [7:0] dofs;
  logic [CW-1:0] dch;
  logic [PW-1:0] dpt;
  logic [31:0] rd_val;
  logic [31:0] wd;
  logic [31:0] clr;
  logic [7:0] ev;
  logic [7:0] irq_st;
  logic [7:0] next_irq_st;

  // Merge written bytes over the current value
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Final rounding of the scaled value
  function automatic logic signed [VW-1:0] round_val(
      input logic signed [VW-1:0] v, input logic [1:0] m);
    logic signed [VW-1:0] fl;
    fl = v & ~FMASK;
    unique case (scale_pkg::round_t'(m))
      scale_pkg::RND_FLOAT: return v;
      scale_pkg::RND_FLOOR: return fl;
      scale_pkg::RND_CEIL: return ((v & FMASK) != '0) ? fl + ONE : fl;
      scale_pkg::RND_NEAR: return (v + HALF) & ~FMASK;
    endcase
  endfunction

  // Field extraction per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_en[c] = cfg[c][scale_pkg::CFG_EN];
      filt_en[c] = cfg[c][scale_pkg::CFG_FILT];
      oor_en[c] = cfg[c][scale_pkg::CFG_OOR];
      act[c] = master_en && ch_en[c]; // RULE_01 RULE_02
    end
  end

  // Source selection and datapath terms for the current channel
  always_comb begin
    sel = cfg[chn][scale_pkg::CFG_SRC_LSB +: scale_pkg::CFG_SRC_W];
    sel_ok = 1'b0;
    sel_val = '0;
    if (sel <= 6'(scale_pkg::SRC_LAST)) begin // RULE_03
      sel_ok = SRC_OK_I[sel];
      sel_val = SRC_DATA_I[sel*VW +: VW];
    end
    fdiff = $signed({raw[chn][VW-1], raw[chn], {G{1'b0}}}) -
            $signed({acc[chn][AW-1], acc[chn]});
    cur = VW'(acc[chn] >>> G);
    oor_hit = oor_en[chn] && (cur < lim_lo[chn] || cur > lim_hi[chn]);
    dx = (VW+1)'(cin[chn]) - (VW+1)'(xlo);
    dy = (VW+1)'(yhi) - (VW+1)'(ylo);
  end

  // Address decode and read mux
  always_comb begin
    ba = {ADDRESS_I, 2'b00};
    dofs = ba[7:0];
    dch = CW'(ba[11:8] - scale_pkg::CH_PAGE);
    ch_hit = ba[11:8] >= scale_pkg::CH_PAGE &&
             (ba[11:8] - scale_pkg::CH_PAGE) < 4'(NCH);
    pt_hit = dofs >= scale_pkg::CH_PT &&
             ((dofs - scale_pkg::CH_PT) >> scale_pkg::PT_SHIFT) < 8'(NPTS);
    dpt = PW'((dofs - scale_pkg::CH_PT) >> scale_pkg::PT_SHIFT);
    dxy = dofs[2];
    rd_val = '0;
    hit = 1'b1;
    if (ba[11:8] == 4'h0) begin
      case (ba)
        scale_pkg::OFS_CTRL: rd_val = 32'(master_en);
        scale_pkg::OFS_IRQ_ST: rd_val = 32'(irq_st);
        scale_pkg::OFS_IRQ_MASK: rd_val = 32'(irq_mask);
        scale_pkg::OFS_OOR: rd_val = 32'(curve_out_of_range_flag);
        default: hit = 1'b0;
      endcase
    end else if (ch_hit && pt_hit) begin
      rd_val = dxy ? py[dch][dpt] : px[dch][dpt];
    end else if (ch_hit) begin
      case (dofs)
        scale_pkg::CH_CFG: rd_val = cfg[dch];
        scale_pkg::CH_TC: rd_val = 32'(tc[dch]);
        scale_pkg::CH_UPD: rd_val = 32'(upd[dch]);
        scale_pkg::CH_MIN: rd_val = lim_lo[dch];
        scale_pkg::CH_MAX: rd_val = lim_hi[dch];
        scale_pkg::CH_IN: rd_val = cin[dch]; // RULE_14
        scale_pkg::CH_OUT: rd_val = cout[dch]; // RULE_15
        scale_pkg::CH_USED: rd_val = 32'(used[dch] | NPTS'(3)); // RULE_13
        default: hit = 1'b0;
      endcase
    end else begin
      hit = 1'b0;
    end
    wd = be_merge(rd_val, WRITEDATA_I, BYTEENABLE_I);
    clr = '0;
    if (wr_go && ba == scale_pkg::OFS_IRQ_ST) begin
      clr = be_merge(32'h0, WRITEDATA_I, BYTEENABLE_I);
    end
  end

  // Bus handshake: one wait cycle, answer on the second edge
  assign wr_go = WRITE_I && !WAITREQUEST_O;
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WAITREQUEST_O <= 1'b1;
      READDATA_O <= '0;
    end else if ((READ_I || WRITE_I) && WAITREQUEST_O) begin
      WAITREQUEST_O <= 1'b0;
      READDATA_O <= READ_I ? rd_val : 32'h0;
    end else begin
      WAITREQUEST_O <= 1'b1;
    end
  end

  // Settings written by software
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      master_en <= 1'b0;
      irq_mask <= '0;
      for (int c = 0; c < NCH; c++) begin
        cfg[c] <= '0;
        tc[c] <= scale_pkg::FILT_TC_DEF; // RULE_05
        upd[c] <= scale_pkg::UPD_DEF; // RULE_10
        lim_lo[c] <= '0; // RULE_07
        lim_hi[c] <= '0;
        used[c] <= '0;
        for (int p = 0; p < NPTS; p++) begin
          px[c][p] <= (p == 1) ? ONE : '0; // RULE_12
          py[c][p] <= '0;
        end
      end
    end else if (wr_go && hit) begin
      if (ba == scale_pkg::OFS_CTRL) begin
        master_en <= wd[scale_pkg::CTRL_EN];
      end
      if (ba == scale_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wd[7:0];
      end
      if (ch_hit && pt_hit) begin
        if (dxy) begin
          py[dch][dpt] <= wd;
        end else begin
          px[dch][dpt] <= wd;
        end
      end else if (ch_hit) begin
        case (dofs)
          scale_pkg::CH_CFG: cfg[dch] <= wd & scale_pkg::CFG_MASK;
          scale_pkg::CH_TC: tc[dch] <= wd[15:0];
          scale_pkg::CH_UPD: upd[dch] <= wd[15:0];
          scale_pkg::CH_MIN: lim_lo[dch] <= wd;
          scale_pkg::CH_MAX: lim_hi[dch] <= wd;
          scale_pkg::CH_USED: used[dch] <= wd[NPTS-1:0]; // RULE_13
          default: ;
        endcase
      end
    end
  end

  // Base tick of one 5 ms step
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 32'(TC1);
      tick_cnt <= (tick_cnt == 32'(TC1)) ? '0 : tick_cnt + 32'h1;
    end
  end

  // Shared divider for filter steps and interpolation
  curve_divider #(.DW(DW)) u_div (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .start_i(div_start),
    .num_i(div_num),
    .den_i(div_den),
    .quo_o(div_quo),
    .done_o(div_done)
  );

  // Channel sequencer, run once per tick over all channels
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= S_IDLE;
      chn <= '0;
      pidx <= '0;
      flo <= 1'b0;
      fhi <= 1'b0;
      xlo <= '0;
      ylo <= '0;
      xhi <= '0;
      yhi <= '0;
      res <= '0;
      div_start <= 1'b0;
      div_num <= '0;
      div_den <= '0;
      ev <= '0;
      curve_out_of_range_flag <= '0;
      for (int c = 0; c < NCH; c++) begin
        raw[c] <= '0;
        acc[c] <= '0;
        cin[c] <= '0;
        cout[c] <= '0;
        upd_cnt[c] <= '0;
      end
    end else begin
      div_start <= 1'b0;
      ev <= '0;
      curve_out_of_range_flag <= curve_out_of_range_flag & oor_en & act;
      unique case (state)
        S_IDLE: begin
          if (tick) begin
            chn <= '0;
            state <= S_CHAN;
          end
        end
        S_CHAN: begin
          if (act[chn] && sel_ok) begin
            raw[chn] <= sel_val; // RULE_09
          end
          state <= act[chn] ? S_FSTART : S_NEXT; // RULE_02
        end
        S_FSTART: begin
          if (filt_en[chn]) begin
            div_num <= DW'(fdiff); // RULE_06
            div_den <= DW'((tc[chn] == 16'h0) ? 16'h1 : tc[chn]); // RULE_05
            div_start <= 1'b1;
            state <= S_FWAIT;
          end else begin
            acc[chn] <= {raw[chn], {G{1'b0}}}; // RULE_04
            state <= S_EVAL;
          end
        end
        S_FWAIT: begin
          if (div_done) begin
            acc[chn] <= acc[chn] + AW'(div_quo); // RULE_04
            state <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (upd_cnt[chn] + 16'h1 >= upd[chn]) begin // RULE_10
            upd_cnt[chn] <= '0;
            cin[chn] <= cur;
            curve_out_of_range_flag[chn] <= oor_hit; // RULE_07
            ev[scale_pkg::IRQ_OOR_LSB + chn] <= oor_hit &&
              !curve_out_of_range_flag[chn];
            pidx <= '0;
            flo <= 1'b0;
            fhi <= 1'b0;
            state <= S_SCAN;
          end else begin
            upd_cnt[chn] <= upd_cnt[chn] + 16'h1;
            state <= S_NEXT;
          end
        end
        S_SCAN: begin
          // Nearest used point at or below, and strictly above, the input
          if (pidx < PW'(2) || used[chn][pidx]) begin // RULE_13
            if (px[chn][pidx] <= cin[chn] &&
                (!flo || px[chn][pidx] > xlo)) begin // RULE_16
              flo <= 1'b1;
              xlo <= px[chn][pidx];
              ylo <= py[chn][pidx];
            end
            if (px[chn][pidx] > cin[chn] &&
                (!fhi || px[chn][pidx] < xhi)) begin
              fhi <= 1'b1;
              xhi <= px[chn][pidx];
              yhi <= py[chn][pidx];
            end
          end
          if (pidx == PW'(NPTS - 1)) begin
            state <= S_ISTART;
          end else begin
            pidx <= pidx + PW'(1);
          end
        end
        S_ISTART: begin
          if (!flo || !fhi) begin
            res <= flo ? ylo : yhi; // RULE_16
            state <= S_STORE;
          end else begin
            div_num <= DW'(dx) * DW'(dy); // RULE_16
            div_den <= DW'(xhi) - DW'(xlo);
            div_start <= 1'b1;
            state <= S_IWAIT;
          end
        end
        S_IWAIT: begin
          if (div_done) begin
            res <= ylo + VW'(div_quo);
            state <= S_STORE;
          end
        end
        S_STORE: begin
          if (act[chn]) begin // RULE_01
            cout[chn] <= round_val(res,
              cfg[chn][scale_pkg::CFG_RND_LSB +: 2]); // RULE_11
            ev[scale_pkg::IRQ_DONE_LSB + chn] <= 1'b1;
          end
          state <= S_NEXT;
        end
        S_NEXT: begin
          if (chn == CW'(NCH - 1)) begin
            state <= S_IDLE;
          end else begin
            chn <= chn + CW'(1);
            state <= S_CHAN;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Sticky events, set wins over a write-one clear
  assign next_irq_st = (irq_st & ~clr[7:0]) | ev;
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_st <= '0;
      IRQ_O <= 1'b0;
      CURVE_OUT_OF_RANGE_FLAG_O <= '0;
    end else begin
      irq_st <= next_irq_st;
      IRQ_O <= |(next_irq_st & irq_mask);
      CURVE_OUT_OF_RANGE_FLAG_O <= curve_out_of_range_flag; // RULE_08
    end
  end

  // Checks on the scaling behaviour
  property p_master_gate;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      ev[7:4] != 4'h0 |-> $past(master_en);
  endproperty
  a_master_gate: assert property (p_master_gate) // RULE_01
    else $error("result stored with master disabled");

  property p_chan_gate;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      (ev[7:4] & ~$past(ch_en)) == 4'h0;
  endproperty
  a_chan_gate: assert property (p_chan_gate) // RULE_02
    else $error("result stored on disabled channel");

  property p_raw_pass;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      state == S_FSTART && !filt_en[chn] |=>
        state == S_EVAL && acc[$past(chn)] == {$past(raw[chn]), 8'h00};
  endproperty
  a_raw_pass: assert property (p_raw_pass) // RULE_04
    else $error("unfiltered input not passed through");

  property p_oor_enable;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      (curve_out_of_range_flag & ~$past(oor_en)) == 4'h0;
  endproperty
  a_oor_enable: assert property (p_oor_enable) // RULE_07
    else $error("range flag set while detection off");

  property p_flag_out;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      ev[3:0] != 4'h0 |=> (CURVE_OUT_OF_RANGE_FLAG_O & $past(ev[3:0])) != 0;
  endproperty
  a_flag_out: assert property (p_flag_out) // RULE_08
    else $error("range flag not driven out");

  property p_hold_lost;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      state == S_CHAN && !sel_ok |=> raw[$past(chn)] == $past(raw[chn]);
  endproperty
  a_hold_lost: assert property (p_hold_lost) // RULE_09
    else $error("sample changed while source lost");

  property p_tick;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      tick |-> tick_cnt == 32'h0 && $past(tick_cnt) == 32'(TC1);
  endproperty
  a_tick: assert property (p_tick) // RULE_10
    else $error("step tick spacing wrong");

  property p_between;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      state == S_STORE && flo && fhi |->
        (res >= ylo && res <= yhi) || (res <= ylo && res >= yhi);
  endproperty
  a_between: assert property (p_between) // RULE_16
    else $error("interpolated value outside segment");

  property p_round;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      state == S_STORE && act[chn] &&
        cfg[chn][scale_pkg::CFG_RND_LSB +: 2] != 2'h0 |=>
        (cout[$past(chn)] & FMASK) == '0;
  endproperty
  a_round: assert property (p_round) // RULE_11
    else $error("rounded output has a fraction");

  c_filter: cover property (@(posedge CLOCK_I) div_done && state == S_FWAIT);
  c_interp: cover property (@(posedge CLOCK_I) state == S_IWAIT && div_done);
  c_clamp: cover property (@(posedge CLOCK_I) state == S_ISTART && !flo);
  c_irq: cover property (@(posedge CLOCK_I) $rose(IRQ_O));
endmodule // scale_curves

// *** src_model.sv ***
// Measurement source model: one sample word and presence bit per code
// Assumes the bench calls put right after a rising clock edge
`timescale 1ns/1ps
module src_model (
  // Clock
  input wire logic clk_i,
  // Samples and presence
  output logic [scale_pkg::NSRC*scale_pkg::VAL_W-1:0] data_o,
  output logic [scale_pkg::NSRC-1:0] ok_o
);
  logic [31:0] val [scale_pkg::NSRC];
  logic [scale_pkg::NSRC-1:0] ok_n;
  // Nothing lost, all samples zero at start
  initial begin
    data_o = '0;
    ok_o = '1;
    ok_n = '1;
    for (int c = 0; c < scale_pkg::NSRC; c++) val[c] = '0;
  end
  // Word and presence change together; lost sources show the inverse
  always @(posedge clk_i) begin
    ok_o <= ok_n;
    for (int c = 0; c < scale_pkg::NSRC; c++)
      data_o[c*32+:32] <= ok_n[c] ? val[c] : ~val[c];
  end
  // Takes effect at the next rising edge, never at the current one
  task automatic put(input int c, input logic [31:0] v, input logic ok);
    val[c] <= v;
    ok_n[c] <= ok;
  endtask
endmodule // src_model

// *** tb_top.sv ***
// Self-checking bench for the scaling block over its Avalon-MM port
// Assumes the source model feeds every sample word
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [9:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wait_req;
  logic [scale_pkg::NSRC*scale_pkg::VAL_W-1:0] src_data;
  logic [scale_pkg::NSRC-1:0] src_ok;
  logic [3:0] flag;
  logic irq;
  logic [31:0] q;
  logic [31:0] ex [4] = '{32'h28000, 32'h20000, 32'h30000, 32'h30000};
  int fails = 0;
  int samples_checked = 0;
  // Clock of 100 ns
  always #50 clk = ~clk;
  // Short tick keeps each step at 300 clocks
  scale_curves #(.TICK_CYCLES(300)) u_scale_curves (
    .CLOCK_I(clk), .RESETN_I(rst_n), .ADDRESS_I(addr), .READ_I(rd_en),
    .WRITE_I(wr_en), .BYTEENABLE_I(4'hf), .WRITEDATA_I(wdata),
    .READDATA_O(rdata), .WAITREQUEST_O(wait_req), .SRC_DATA_I(src_data),
    .SRC_OK_I(src_ok), .CURVE_OUT_OF_RANGE_FLAG_O(flag), .IRQ_O(irq));
  src_model u_src_model (.clk_i(clk), .data_o(src_data), .ok_o(src_ok));
  // Verdict and end of run
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Two fresh results, so the second one uses the new settings
  task automatic settle();
    int n;
    for (int k = 0; k < 2; k++) begin
      wr(10'h001, 32'h10);
      n = 0;
      do begin
        bus(1'b0, 10'h001, 32'h0);
        n++;
      end while (q[4] !== 1'b1 && n < 400);
      if (n >= 400) begin
        fails++;
        give_verdict();
      end
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(10'h000, 32'h0);
    rc(10'h041, 32'hc8);
    rc(10'h042, 32'h1e);
    rc(10'h052, 32'h10000);
    rc(10'h047, 32'h3);
    rc(10'h3ff, 32'h0);
    // Line from (0,0) to (1.0,10.0), limits 0 and 0.5, one tick
    wr(10'h053, 32'ha0000);
    wr(10'h042, 32'h1);
    wr(10'h044, 32'h8000);
    wr(10'h002, 32'h1);
    u_src_model.put(41, 32'h4000, 1'b1);
    wr(10'h000, 32'h1);
    // Every rounding mode on an output of 2.5
    for (int m = 0; m < 4; m++) begin
      wr(10'h040, 32'h2901 | 32'(m << 4));
      settle();
      rc(10'h046, ex[m]);
    end
    rc(10'h045, 32'h4000);
    // Input 1.5: clamped output, out of range flag and interrupt
    u_src_model.put(24, 32'h18000, 1'b1);
    wr(10'h040, 32'h1805);
    settle();
    rc(10'h046, 32'ha0000);
    chk({28'h0, flag}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(10'h001, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Lost source keeps the last good sample
    u_src_model.put(24, 32'h0, 1'b0);
    settle();
    rc(10'h045, 32'h18000);
    // Filter on, step from 1.5 to 0.5: input moves only slightly per tick
    u_src_model.put(24, 32'h8000, 1'b1);
    wr(10'h040, 32'h1807);
    settle();
    bus(1'b0, 10'h045, 32'h0);
    chk({31'h0, q > 32'h10000 && q < 32'h18000}, 32'h1);
    rc(10'h046, 32'ha0000);
    // Master off: flag drops, output frozen
    wr(10'h000, 32'h0);
    repeat (3) @(posedge clk);
    chk({28'h0, flag}, 32'h0);
    rc(10'h046, 32'ha0000);
    // Channel off under master on: no result, no event, flag low
    wr(10'h040, 32'h1804);
    wr(10'h000, 32'h1);
    wr(10'h001, 32'hff);
    repeat (700) @(posedge clk);
    rc(10'h001, 32'h0);
    chk({28'h0, flag}, 32'h0);
    rc(10'h046, 32'ha0000);
    give_verdict();
  end
endmodule // tb_top
